/* File: design/compat_cfg_regs.sv */
// release-compat length and general-config store-defaults registers
`timescale 1ns/1ps
`include "compat_cfg_defs.svh"
module compat_cfg_regs (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // command status
    output logic             o_exec_error,
    output logic      [2:0]  o_err_code,
    output logic             o_busy_fail,
    // run-state from outside control
    input  wire logic        i_run_state,
    // interrupt
    output logic             o_irq
);
    compat_cfg_pkg::store_state_t state_ff;
    compat_cfg_pkg::store_state_t nxt_state;
    logic [3:0]  cnt_ff;
    logic [15:0] nv_cfg_ff;       // working non-volatile config
    logic        nv_run_ff;
    logic        run_prev_ff;     // last sampled run-state level
    logic [15:0] saved_cfg_ff;    // persistent copy
    logic        saved_run_ff;
    logic [15:0] shadow_cfg_ff;   // snapshot being written
    logic        shadow_run_ff;
    logic [15:0] aea_ctrl_ff;
    logic [15:0] aea_addr_ff;
    logic [15:0] rdata_ff;
    logic        xe_ff;
    logic [2:0]  err_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_en_ff;
    logic        pending_ff;
    logic [7:0]  str_byte;
    logic [6:0]  str_len;

    // address decode
    wire sel_rc   = (i_addr == `REG_RELEASE_COMPAT);
    wire sel_gc   = (i_addr == `REG_GENERAL_CONFIG);
    wire storing  = (state_ff != compat_cfg_pkg::ST_IDLE);
    wire wr_rc    = i_wr & sel_rc;
    wire wr_gc    = i_wr & sel_gc;
    wire sdc_req  = wr_gc & i_wdata[`SDC_BIT];
    wire sdc_go   = sdc_req & ~storing;
    wire sdc_busy = sdc_req & storing;
    wire rd_rc    = i_rd & sel_rc;
    wire rd_rc_ok = rd_rc & ~storing;
    wire rd_rc_bad = rd_rc & storing;
    wire rd_aea   = i_rd & (i_addr == `REG_AEA_DATA);
    wire store_done = (state_ff == compat_cfg_pkg::ST_DONE);
    wire any_err  = wr_rc | rd_rc_bad | sdc_busy;

    compat_string_rom u_rom (
        .i_index (aea_addr_ff[6:0]),
        .o_byte  (str_byte),
        .o_len   (str_len)
    );

    // read mux; unmapped reads return zero
    function automatic logic [15:0] rd_mux(input logic [7:0] a);
        case (a)
            `REG_RELEASE_COMPAT: rd_mux = storing ? `ZERO16 :
                                 {9'h000, str_len};
            `REG_GENERAL_CONFIG: rd_mux = `ZERO16;
            `REG_AEA_CTRL:       rd_mux = aea_ctrl_ff;
            `REG_AEA_ADDR:       rd_mux = aea_addr_ff;
            `REG_AEA_DATA:       rd_mux = {8'h00, str_byte};
            `REG_IRQ_STATUS:     rd_mux = {14'h0000, irq_stat_ff};
            `REG_IRQ_ENABLE:     rd_mux = {14'h0000, irq_en_ff};
            `REG_NV_CONFIG:      rd_mux = nv_cfg_ff;
            `REG_NV_RUN_STATE:   rd_mux = {15'h0000, nv_run_ff};
            `REG_ERR_INFO:       rd_mux = {12'h000, xe_ff, err_ff};
            default:             rd_mux = `ZERO16;
        endcase
    endfunction : rd_mux

    // write answer: zero on refused write, pending id on a config write while storing,
    // otherwise the written value
    wire [15:0] wr_answer = wr_rc ? `ZERO16 :
                            (wr_gc & storing) ? `PENDING_ID :
                            i_wdata;

    // store sequence: snapshot, erase, write, commit atomically
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            compat_cfg_pkg::ST_IDLE:
                if (sdc_go) nxt_state = compat_cfg_pkg::ST_ERASE;
            compat_cfg_pkg::ST_ERASE:
                if (cnt_ff == `STORE_CYCLES)
                    nxt_state = compat_cfg_pkg::ST_WRITE;
            compat_cfg_pkg::ST_WRITE:
                if (cnt_ff == `STORE_CYCLES)
                    nxt_state = compat_cfg_pkg::ST_DONE;
            compat_cfg_pkg::ST_DONE:
                nxt_state = compat_cfg_pkg::ST_IDLE;  // flag self-clears
            default:
                nxt_state = compat_cfg_pkg::ST_IDLE;
        endcase
    end

    // state and phase counter
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_ff <= compat_cfg_pkg::ST_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (nxt_state != state_ff) ? 4'h0 : cnt_ff + 4'h1;
        end
    end

    // persistent copy survives reset; commit only on completion
    always_ff @(posedge i_clk_sys) begin
        if (store_done) begin
            saved_cfg_ff <= shadow_cfg_ff;
            saved_run_ff <= shadow_run_ff;
        end
        if (sdc_go) begin
            shadow_cfg_ff <= nv_cfg_ff;
            shadow_run_ff <= nv_run_ff;
        end
    end

    // working copy reloads from saved set at reset; run state is taken
    // only when it changes, so the reloaded value is not overwritten
    always_ff @(posedge i_clk_sys) begin
        run_prev_ff <= i_run_state;
        if (i_srst) begin
            nv_cfg_ff <= saved_cfg_ff;
            nv_run_ff <= saved_run_ff;
        end else begin
            if (i_wr && i_addr == `REG_NV_CONFIG) nv_cfg_ff <= i_wdata;
            if (i_run_state != run_prev_ff) nv_run_ff <= i_run_state;
        end
    end

    // AEA set, read data and error status
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            aea_ctrl_ff <= `ZERO16;
            aea_addr_ff <= `ZERO16;
            rdata_ff    <= `ZERO16;
            xe_ff       <= 1'b0;
            err_ff      <= compat_cfg_pkg::ERR_NONE;
            pending_ff  <= 1'b0;
        end else begin
            rdata_ff <= i_wr ? wr_answer : rd_mux(i_addr);
            pending_ff <= wr_gc & storing;
            if (rd_rc_ok) begin
                aea_ctrl_ff <= `AEA_CTRL_STRING;
                aea_addr_ff <= `ZERO16;
            end else if (rd_aea) begin
                aea_addr_ff <= aea_addr_ff + 16'h0001;
            end else if (i_wr && i_addr == `REG_AEA_ADDR) begin
                aea_addr_ff <= i_wdata;
            end
            if (i_wr || i_rd) begin
                xe_ff  <= any_err;
                err_ff <= wr_rc ? compat_cfg_pkg::ERR_RNW :
                          any_err ? compat_cfg_pkg::ERR_CIP :
                          compat_cfg_pkg::ERR_NONE;
            end
        end
    end

    // interrupt status: set wins over clear
    wire [1:0] irq_evt = {any_err, store_done};
    wire [1:0] irq_clr = (i_wr && i_addr == `REG_IRQ_CLEAR) ?
                         i_wdata[1:0] : 2'b00;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_stat_ff <= 2'b00;
            irq_en_ff   <= 2'b00;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
            if (i_wr && i_addr == `REG_IRQ_ENABLE)
                irq_en_ff <= i_wdata[1:0];
        end
    end

    assign o_rdata      = rdata_ff;
    assign o_exec_error = xe_ff;
    assign o_err_code   = err_ff;
    assign o_busy_fail  = pending_ff;
    assign o_irq        = |(irq_stat_ff & irq_en_ff);

    // assertions
    property p_wr_rc_err;
        @(posedge i_clk_sys) disable iff (i_srst)
        wr_rc |=> o_exec_error && o_err_code == compat_cfg_pkg::ERR_RNW;
    endproperty
    a_wr_rc_err: assert property (p_wr_rc_err)
        else $error("release compat write not refused");
    property p_rd_len;
        @(posedge i_clk_sys) disable iff (i_srst)
        rd_rc_ok |=> o_rdata == {9'h000, str_len} && o_rdata <= 16'h0050;
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("bad string length");
    property p_aea_set;
        @(posedge i_clk_sys) disable iff (i_srst)
        rd_rc_ok |=> aea_ctrl_ff == `AEA_CTRL_STRING && aea_addr_ff == 0;
    endproperty
    a_aea_set: assert property (p_aea_set)
        else $error("AEA set not aimed at string");
    property p_rd_fail;
        @(posedge i_clk_sys) disable iff (i_srst)
        rd_rc_bad |=> o_rdata == 16'h0000 && o_exec_error;
    endproperty
    a_rd_fail: assert property (p_rd_fail)
        else $error("failed read not zero");
    property p_sdc_zero;
        @(posedge i_clk_sys) disable iff (i_srst)
        (i_rd && sel_gc) |=> o_rdata == 16'h0000;
    endproperty
    a_sdc_zero: assert property (p_sdc_zero)
        else $error("config read not zero");
    sequence s_store_run;
        state_ff == compat_cfg_pkg::ST_ERASE [*1] ##[1:40] store_done;
    endsequence
    property p_store;
        @(posedge i_clk_sys) disable iff (i_srst)
        sdc_go |=> s_store_run ##1 saved_cfg_ff == $past(shadow_cfg_ff);
    endproperty
    a_store: assert property (p_store)
        else $error("store did not complete");
    property p_zero_noop;
        @(posedge i_clk_sys) disable iff (i_srst)
        (wr_gc && !i_wdata[`SDC_BIT] && !storing) |=> !storing;
    endproperty
    a_zero_noop: assert property (p_zero_noop)
        else $error("zero write started store");
    property p_pending;
        @(posedge i_clk_sys) disable iff (i_srst)
        (wr_gc && storing) |=> o_rdata == `PENDING_ID;
    endproperty
    a_pending: assert property (p_pending)
        else $error("pending id missing");
    property p_reload;
        @(posedge i_clk_sys) i_srst |=> nv_cfg_ff === $past(saved_cfg_ff);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reset did not reload");
endmodule : compat_cfg_regs

/* File: design/compat_string_rom.sv */
// compatibility string storage with length and byte lookup
`timescale 1ns/1ps
`include "compat_cfg_defs.svh"
module compat_string_rom (
    // byte lookup
    input  wire logic [6:0] i_index,
    output logic      [7:0] o_byte,
    // total length including terminator
    output logic      [6:0] o_len
);
    // earliest compatible release id, space, X.Y.Z per field
    // major and patch kept within 0 to 255
    // "FW 1.0.0:HW 3.2.1" plus null terminator
    localparam int          LEN = 18;
    localparam logic [143:0] STR = {"FW 1.0.0:HW 3.2.1", 8'h00};
    // bytes past the string read as null
    assign o_byte = (i_index < 7'(LEN)) ?
                    STR[8'(143 - 8 * i_index) -: 8] : 8'h00;
    assign o_len  = 7'(LEN);
endmodule : compat_string_rom

/* File: shared/compat_cfg_defs.svh */
// constants for the release-compat and general-config register block
`ifndef COMPAT_CFG_DEFS_SVH
`define COMPAT_CFG_DEFS_SVH
`define REG_RELEASE_COMPAT   8'h07
`define REG_GENERAL_CONFIG   8'h08
`define REG_AEA_CTRL         8'h09
`define REG_AEA_ADDR         8'h0A
`define REG_AEA_DATA         8'h0B
`define REG_IRQ_STATUS       8'h20
`define REG_IRQ_ENABLE       8'h21
`define REG_IRQ_CLEAR        8'h22
`define REG_NV_CONFIG        8'h23
`define REG_NV_RUN_STATE     8'h24
`define REG_ERR_INFO         8'h25
`define SDC_BIT              15
`define STR_MAX_LEN          7'h50
`define STR_INDEX_W          7
`define CFG_RESET            16'h0000
`define ZERO16               16'h0000
`define AEA_CTRL_STRING      16'h0001
`define STORE_CYCLES         4'hF
`define IRQ_STORE_DONE       0
`define IRQ_EXEC_ERROR       1
`define PENDING_ID           16'h0001
`endif

/* File: shared/compat_cfg_pkg.sv */
// types for the release-compat and general-config register block
package compat_cfg_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_WRITE = 2'b11,
        ST_DONE  = 2'b10
    } store_state_t;
    typedef enum logic [2:0] {
        ERR_NONE = 3'h0,
        ERR_CIP  = 3'h1,
        ERR_CII  = 3'h2,
        ERR_EXF  = 3'h3,
        ERR_VSE  = 3'h4,
        ERR_RNW  = 3'h5
    } err_code_t;
endpackage : compat_cfg_pkg

/* File: tb/compat_host.sv */
// host model that issues register commands to the config block
`timescale 1ns/1ps
module compat_host (
    // clock
    input  wire logic        i_clk_sys,
    // register port
    output logic      [7:0]  o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd,
    input  wire logic [15:0] i_rdata
);
    // idle bus at time zero
    initial begin
        o_addr  = 8'h00;
        o_wdata = 16'h0000;
        o_wr    = 1'h0;
        o_rd    = 1'h0;
    end
    // one-cycle strobe, answer taken in the cycle after it;
    // versions are only passed on, patch levels never compared
    task automatic acc(input logic we, input logic [7:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        @(posedge i_clk_sys);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= we;
        o_rd    <= !we;
        @(posedge i_clk_sys);
        o_wr    <= 1'h0;
        o_rd    <= 1'h0;
        #1;
        q = i_rdata;
    endtask : acc
endmodule : compat_host

/* File: tb/release_compat_and_config_store_regs_test.sv */
// self-checking bench for the release-compat and config registers
`timescale 1ns/1ps
`include "compat_cfg_defs.svh"
module release_compat_and_config_store_regs_test;
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic        run_state = 1'h0;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        xe;
    logic [2:0]  code;
    logic        busy;
    logic        irq;
    logic [15:0] q;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    string       s = "FW 1.0.0:HW 3.2.1";
    // 10 MHz clock
    always #50 clk = ~clk;
    compat_host i_host (.i_clk_sys(clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
    compat_cfg_regs i_dut (.i_clk_sys(clk), .i_srst(srst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_exec_error(xe), .o_err_code(code), .o_busy_fail(busy),
        .i_run_state(run_state), .o_irq(irq));
    // compare and report
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic w(logic [7:0] a, logic [15:0] d, logic [15:0] exp);
        i_host.acc(1'h1, a, d, q);
        check($sformatf("answer %h", a), q, exp);
    endtask : w
    task automatic r(logic [7:0] a, logic [15:0] exp);
        i_host.acc(1'h0, a, 16'h0000, q);
        check($sformatf("reg %h", a), q, exp);
    endtask : r
    task automatic err(logic x, logic [2:0] c);
        check("exec_error", {15'h0000, xe}, {15'h0000, x});
        check("err_code", {13'h0000, code}, {13'h0000, c});
    endtask : err
    task automatic reset();
        srst <= 1'h1;
        repeat (6) @(posedge clk);
        srst <= 1'h0;
    endtask : reset
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end
    // main sequence
    initial begin
        reset();
        r(`REG_GENERAL_CONFIG, 16'h0000);
        check("irq", {15'h0000, irq}, 16'h0000);
        $display("test reset done");
        r(`REG_RELEASE_COMPAT, 16'h0012);
        err(1'h0, 3'h0);
        check("len max", {15'h0000, q > 16'h0050}, 16'h0000);
        r(`REG_AEA_CTRL, 16'h0001);
        r(`REG_AEA_ADDR, 16'h0000);
        for (int i = 0; i < 18; i++) begin
            r(`REG_AEA_DATA, (i < 17) ? {8'h00, s[i]} : 16'h0000);
        end
        $display("test string done");
        w(`REG_RELEASE_COMPAT, 16'h1234, 16'h0000);
        err(1'h1, 3'h5);
        r(`REG_AEA_CTRL, 16'h0001);
        w(`REG_IRQ_ENABLE, 16'h0002, 16'h0002);
        check("irq on", {15'h0000, irq}, 16'h0001);
        r(`REG_IRQ_STATUS, 16'h0002);
        w(`REG_IRQ_ENABLE, 16'h0000, 16'h0000);
        check("irq masked", {15'h0000, irq}, 16'h0000);
        w(`REG_IRQ_CLEAR, 16'h0002, 16'h0002);
        r(`REG_IRQ_STATUS, 16'h0000);
        r(8'h30, 16'h0000);
        $display("test error and irq done");
        w(`REG_NV_CONFIG, 16'hA5A5, 16'hA5A5);
        run_state <= 1'h1;
        w(`REG_GENERAL_CONFIG, 16'h7FFF, 16'h7FFF);
        repeat (40) @(posedge clk);
        r(`REG_IRQ_STATUS, 16'h0000);
        r(`REG_GENERAL_CONFIG, 16'h0000);
        w(`REG_IRQ_ENABLE, 16'h0001, 16'h0001);
        w(`REG_GENERAL_CONFIG, 16'h8000, 16'h8000);
        w(`REG_GENERAL_CONFIG, 16'h8000, 16'h0001);
        check("busy", {15'h0000, busy}, 16'h0001);
        err(1'h1, 3'h1);
        r(`REG_RELEASE_COMPAT, 16'h0000);
        err(1'h1, 3'h1);
        for (int k = 0; k < 60 && irq !== 1'h1; k++) @(posedge clk);
        check("store done", {15'h0000, irq}, 16'h0001);
        r(`REG_GENERAL_CONFIG, 16'h0000);
        $display("test store done");
        w(`REG_NV_CONFIG, 16'h1234, 16'h1234);
        run_state <= 1'h0;
        reset();
        r(`REG_NV_CONFIG, 16'hA5A5);
        r(`REG_NV_RUN_STATE, 16'h0001);
        w(`REG_NV_CONFIG, 16'h5A5A, 16'h5A5A);
        w(`REG_GENERAL_CONFIG, 16'h8000, 16'h8000);
        repeat (5) @(posedge clk);
        reset();
        r(`REG_NV_CONFIG, 16'hA5A5);
        r(`REG_NV_RUN_STATE, 16'h0001);
        $display("test reload done");
        results();
    end
endmodule : release_compat_and_config_store_regs_test
